/* logic/rtc_core.sv */
// real time clock core: counters, alarm, flags, calibration and regulator select
`timescale 1ns/1ns
module rtc_core (
    input  wire logic                 mclk_i,
    input  wire logic                 rstn_i,
    input  wire logic                 tb_en_i,
    input  wire logic                 clock_disable_i,
    input  wire logic [4:0]           calibration_word_i,
    input  wire logic [1:0]           calibration_mode_i,
    input  wire rtc_pkg::rtc_alarm_t  alarm_i,
    input  wire logic                 alarm_we_i,
    input  wire rtc_pkg::rtc_time_t   time_i,
    input  wire logic                 time_we_i,
    input  wire logic [2:0]           mask_i,
    input  wire logic                 mask_we_i,
    input  wire logic [2:0]           flag_clr_i,
    input  wire logic [1:0]           pwr_state_i,
    input  wire logic [4:0]           power_up_mode_straps_i,
    output logic                      clock_stopped_o,
    output rtc_pkg::rtc_time_t        time_o,
    output rtc_pkg::rtc_alarm_t       alarm_o,
    output logic [4:0]                calibration_word_o,
    output logic [1:0]                calibration_mode_o,
    output logic [2:0]                flags_o,
    output logic [2:0]                mask_o,
    output logic                      irq_o,
    output logic                      power_up_req_o,
    output logic                      backup_domain_regulator_en_o,
    output logic                      backup_domain_regulator_1v3_o
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    rtc_pkg::rtc_time_t  tim_reg,   tim_next;
    rtc_pkg::rtc_alarm_t alm_reg,   alm_next;
    logic [4:0]          cal_reg,   cal_next;
    logic [1:0]          mode_reg,  mode_next;
    logic                dis_reg,   dis_next;
    logic [2:0]          flag_reg,  flag_next;
    logic [2:0]          mask_reg,  mask_next;
    logic                irq_reg,   irq_next;
    logic                pup_reg,   pup_next;
    logic                reg_en_reg, reg_en_next;
    logic                v13_reg,   v13_next;
    logic                tick;
    logic                cal_on;
    logic                alarm_hit;
    logic [2:0]          set_vec;

    function automatic logic strap_high(input logic [4:0] s);
        strap_high = (s >= rtc_pkg::STRAP_HI_FIRST) && (s <= rtc_pkg::STRAP_HI_LAST);
    endfunction : strap_high

    // ---------------------------------------------------------------
    // calibration enable by mode and supply
    // ---------------------------------------------------------------
    always_comb begin
        case (rtc_pkg::rtc_cal_mode_t'(mode_reg))
            rtc_pkg::RTC_CAL_OFF:     cal_on = 1'b0;
            rtc_pkg::RTC_CAL_NO_COIN: cal_on = (pwr_state_i != rtc_pkg::RTC_PWR_COIN);
            rtc_pkg::RTC_CAL_ALL:     cal_on = 1'b1;
            default:                  cal_on = 1'b0;
        endcase
    end

    // calibration touches only this divider, never the slow clock outputs
    rtc_tick_div u_div (
        .mclk_i     (mclk_i),
        .rstn_i     (rstn_i),
        .tb_en_i    (tb_en_i),
        .run_i      (~dis_reg),
        .cal_on_i   (cal_on),
        .cal_word_i (cal_reg),
        .tick_o     (tick)
    );

    // ---------------------------------------------------------------
    // counters and configuration
    // ---------------------------------------------------------------
    always_comb begin
        tim_next  = tim_reg;
        alm_next  = alm_reg;
        cal_next  = calibration_word_i;
        mode_next = calibration_mode_i;
        dis_next  = clock_disable_i;
        if (alarm_we_i) begin
            alm_next = alarm_i;
        end
        if (time_we_i) begin
            tim_next = time_i;
        end else if (tick) begin
            if (tim_reg.seconds >= rtc_pkg::SEC_DAY_LAST) begin
                tim_next.seconds = rtc_pkg::SEC_RST;
                tim_next.days    = tim_reg.days + 15'h0001;
            end else begin
                tim_next.seconds = tim_reg.seconds + 17'h00001;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tim_reg  <= '{seconds: rtc_pkg::SEC_RST, days: rtc_pkg::DAY_RST};
            alm_reg  <= '{alarm_seconds_value: rtc_pkg::SEC_RST, alarm_day_value: rtc_pkg::DAY_RST};
            cal_reg  <= rtc_pkg::CAL_RST;
            mode_reg <= rtc_pkg::RTC_CAL_OFF;
            dis_reg  <= 1'b0;
        end else begin
            tim_reg  <= tim_next;
            alm_reg  <= alm_next;
            cal_reg  <= cal_next;
            mode_reg <= mode_next;
            dis_reg  <= dis_next;
        end
    end

    // ---------------------------------------------------------------
    // interrupt flags, masks and wake request
    // ---------------------------------------------------------------
    assign alarm_hit = (tim_reg.seconds == alm_reg.alarm_seconds_value) &&
                       (tim_reg.days == alm_reg.alarm_day_value);

    always_comb begin
        set_vec              = 3'h0;
        set_vec[rtc_pkg::IRQ_ONE_SEC] = tick;
        // alarm match is a level: it re-sets the flag each cycle it holds
        set_vec[rtc_pkg::IRQ_ALARM]   = alarm_hit;
        flag_next = (flag_reg & ~flag_clr_i) | set_vec;
        mask_next = mask_we_i ? mask_i : mask_reg;
        irq_next  = |(flag_next & ~mask_next);
        pup_next  = pup_reg;
        if (set_vec[rtc_pkg::IRQ_ALARM] && (pwr_state_i != rtc_pkg::RTC_PWR_ON)) begin
            pup_next = 1'b1;
        end else if (pwr_state_i == rtc_pkg::RTC_PWR_ON) begin
            pup_next = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flag_reg <= rtc_pkg::FLAG_RST;
            mask_reg <= rtc_pkg::MASK_RST;
            irq_reg  <= 1'b0;
            pup_reg  <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            mask_reg <= mask_next;
            irq_reg  <= irq_next;
            pup_reg  <= pup_next;
        end
    end

    // ---------------------------------------------------------------
    // backup regulator
    // ---------------------------------------------------------------
    always_comb begin
        reg_en_next = 1'b1;
        v13_next    = strap_high(power_up_mode_straps_i) && (pwr_state_i == rtc_pkg::RTC_PWR_ON);
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_en_reg <= 1'b0;
            v13_reg    <= 1'b0;
        end else begin
            reg_en_reg <= reg_en_next;
            v13_reg    <= v13_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign clock_stopped_o               = dis_reg;
    assign time_o                        = tim_reg;
    assign alarm_o                       = alm_reg;
    assign calibration_word_o            = cal_reg;
    assign calibration_mode_o            = mode_reg;
    assign flags_o                       = flag_reg;
    assign mask_o                        = mask_reg;
    assign irq_o                         = irq_reg;
    assign power_up_req_o                = pup_reg;
    assign backup_domain_regulator_en_o  = reg_en_reg;
    assign backup_domain_regulator_1v3_o = v13_reg;
endmodule : rtc_core

/* logic/rtc_pkg.sv */
// constants and types of the real time clock block
package rtc_pkg;
    localparam int          TB_DIV_NOM     = 32768;
    localparam logic [15:0] DIV_LAST_NOM   = 16'h7fff;
    localparam logic [16:0] SEC_DAY_LAST   = 17'h1517f;
    localparam logic [16:0] SEC_RST        = 17'h00000;
    localparam logic [14:0] DAY_RST        = 15'h0000;
    localparam logic [4:0]  CAL_RST        = 5'h00;
    localparam logic [2:0]  MASK_RST       = 3'h7;
    localparam logic [2:0]  FLAG_RST       = 3'h4;
    localparam int          IRQ_ONE_SEC    = 0;
    localparam int          IRQ_ALARM      = 1;
    localparam int          IRQ_TMR_RST    = 2;
    localparam logic [4:0]  STRAP_HI_FIRST = 5'h06;
    localparam logic [4:0]  STRAP_HI_LAST  = 5'h09;

    typedef enum logic [1:0] {
        RTC_CAL_OFF     = 2'b00,
        RTC_CAL_NO_COIN = 2'b01,
        RTC_CAL_RSVD    = 2'b10,
        RTC_CAL_ALL     = 2'b11
    } rtc_cal_mode_t;

    typedef enum logic [1:0] {
        RTC_PWR_OFF  = 2'b00,
        RTC_PWR_ON   = 2'b01,
        RTC_PWR_COIN = 2'b10
    } rtc_pwr_t;

    typedef struct packed {
        logic [16:0] alarm_seconds_value;
        logic [14:0] alarm_day_value;
    } rtc_alarm_t;

    typedef struct packed {
        logic [16:0] seconds;
        logic [14:0] days;
    } rtc_time_t;
endpackage : rtc_pkg

/* logic/rtc_tick_div.sv */
// calibrated one-second tick divider
`timescale 1ns/1ns
module rtc_tick_div (
    input  wire logic                mclk_i,
    input  wire logic                rstn_i,
    input  wire logic                tb_en_i,
    input  wire logic                run_i,
    input  wire logic                cal_on_i,
    input  wire logic [4:0]          cal_word_i,
    output logic                     tick_o
);
    logic [15:0] cnt_reg,  cnt_next;
    logic        tick_reg, tick_next;
    logic [15:0] last;

    // ---------------------------------------------------------------
    // signed correction moves end of period
    // ---------------------------------------------------------------
    always_comb begin
        last = rtc_pkg::DIV_LAST_NOM;
        if (cal_on_i) begin
            last = rtc_pkg::DIV_LAST_NOM - {{11{cal_word_i[4]}}, cal_word_i};
        end
    end

    always_comb begin
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (run_i && tb_en_i) begin
            if (cnt_reg >= last) begin
                cnt_next  = 16'h0000;
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg  <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_o = tick_reg;
endmodule : rtc_tick_div

/* tb/rtc_core_monitor.sv */
// assertion checker of the real time clock core
`timescale 1ns/1ns
module rtc_core_monitor (
    input wire logic                mclk_i,
    input wire logic                rstn_i,
    input wire logic                time_we_i,
    input wire logic [2:0]          mask_i,
    input wire logic                mask_we_i,
    input wire logic [2:0]          flag_clr_i,
    input wire logic [1:0]          pwr_state_i,
    input wire logic [4:0]          power_up_mode_straps_i,
    input wire rtc_pkg::rtc_time_t  time_o,
    input wire rtc_pkg::rtc_alarm_t alarm_o,
    input wire logic [2:0]          flags_o,
    input wire logic [2:0]          mask_o,
    input wire logic                irq_o,
    input wire logic                power_up_req_o,
    input wire logic                backup_domain_regulator_en_o,
    input wire logic                backup_domain_regulator_1v3_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    a_irq_line: assert property (irq_o == |(flags_o & ~mask_o))
        else $error("irq line wrong");
    a_mask_load: assert property (mask_we_i |=> mask_o == $past(mask_i))
        else $error("mask not loaded");
    a_flag_hold: assert property (flags_o[0] && !flag_clr_i[0] |=> flags_o[0])
        else $error("flag lost");
    a_sec_step: assert property (!$past(time_we_i) && $changed(time_o.seconds) |-> time_o.seconds ==
        (($past(time_o.seconds) == rtc_pkg::SEC_DAY_LAST) ? 17'h00000 : $past(time_o.seconds) + 17'h00001))
        else $error("seconds step wrong");
    a_sec_max: assert property (time_o.seconds <= rtc_pkg::SEC_DAY_LAST)
        else $error("seconds too large");
    a_day_step: assert property (!$past(time_we_i) && $changed(time_o.days) |->
        time_o.days == $past(time_o.days) + 15'h0001 && time_o.seconds == 17'h00000)
        else $error("day step wrong");
    a_tick_flag: assert property (!$past(time_we_i) && $changed(time_o.seconds) |-> flags_o[0])
        else $error("tick flag missing");
    a_alarm_set: assert property (time_o.seconds == alarm_o.alarm_seconds_value &&
        time_o.days == alarm_o.alarm_day_value |=> flags_o[1])
        else $error("alarm flag missing");
    a_wake_on: assert property (pwr_state_i == rtc_pkg::RTC_PWR_ON |=> !power_up_req_o)
        else $error("wake request while on");
    a_reg_keep: assert property (backup_domain_regulator_en_o |=> backup_domain_regulator_en_o)
        else $error("regulator disabled");
    a_volt_sel: assert property (1'b1 |=> backup_domain_regulator_1v3_o ==
        ($past(power_up_mode_straps_i) >= rtc_pkg::STRAP_HI_FIRST && $past(power_up_mode_straps_i)
        <= rtc_pkg::STRAP_HI_LAST && $past(pwr_state_i) == rtc_pkg::RTC_PWR_ON))
        else $error("voltage select wrong");
endmodule : rtc_core_monitor
bind rtc_core rtc_core_monitor rtc_core_monitor_inst (.mclk_i, .rstn_i, .time_we_i, .mask_i, .mask_we_i,
    .flag_clr_i, .pwr_state_i, .power_up_mode_straps_i, .time_o, .alarm_o, .flags_o, .mask_o, .irq_o,
    .power_up_req_o, .backup_domain_regulator_en_o, .backup_domain_regulator_1v3_o);

/* tb/rtc_tb_source.sv */
// time base source standing in for the crystal oscillator
`timescale 1ns/1ns
module rtc_tb_source (
    input  wire logic mclk_i,
    input  wire logic rstn_i,
    input  wire logic run_i,
    output logic      tb_en_o
);
    // fixed rate, never touched by calibration
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) tb_en_o <= 1'b0;
        else tb_en_o <= run_i;
    end
endmodule : rtc_tb_source

/* tb/tb_rtc_core.sv */
// self-checking bench of the real time clock core
`timescale 1ns/1ns
module tb_rtc_core;
    logic                mclk_i = 1'b0;
    logic                rstn_i = 1'b0;
    logic                run = 1'b0;
    logic                tb_en;
    logic                dis = 1'b0;
    logic [4:0]          cal_w = 5'h00;
    logic [1:0]          cal_m = 2'h0;
    rtc_pkg::rtc_alarm_t alarm = 32'h00000000;
    rtc_pkg::rtc_time_t  tim = 32'h00000000;
    logic                alarm_we = 1'b0;
    logic                time_we = 1'b0;
    logic                mask_we = 1'b0;
    logic [2:0]          mask = 3'h0;
    logic [2:0]          clr = 3'h0;
    logic [1:0]          pwr = 2'h1;
    logic [4:0]          straps = 5'h00;
    logic                stopped, irq, wake, reg_en, reg_1v3, exp_1v3;
    rtc_pkg::rtc_time_t  time_q;
    rtc_pkg::rtc_alarm_t alarm_q;
    logic [4:0]          cal_wq;
    logic [1:0]          cal_mq;
    logic [2:0]          flags, mask_q;
    int                  miscompares = 0;
    int                  comparisons = 0;
    int                  n;

    always #2 mclk_i = ~mclk_i;

    rtc_tb_source rtc_tb_source_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .run_i(run), .tb_en_o(tb_en));
    rtc_core rtc_core_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .tb_en_i(tb_en), .clock_disable_i(dis),
        .calibration_word_i(cal_w), .calibration_mode_i(cal_m), .alarm_i(alarm), .alarm_we_i(alarm_we),
        .time_i(tim), .time_we_i(time_we), .mask_i(mask), .mask_we_i(mask_we), .flag_clr_i(clr),
        .pwr_state_i(pwr), .power_up_mode_straps_i(straps), .clock_stopped_o(stopped), .time_o(time_q),
        .alarm_o(alarm_q), .calibration_word_o(cal_wq), .calibration_mode_o(cal_mq), .flags_o(flags),
        .mask_o(mask_q), .irq_o(irq), .power_up_req_o(wake), .backup_domain_regulator_en_o(reg_en),
        .backup_domain_regulator_1v3_o(reg_1v3));

    task automatic step(input int c);
        repeat (c) @(posedge mclk_i);
        #1;
    endtask : step
    task automatic pulse(ref logic we);
        we = 1'b1;
        step(1);
        we = 1'b0;
    endtask : pulse
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic stop_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task automatic wait_tick(output int cyc);
        logic [16:0] s;
        s = time_q.seconds;
        for (cyc = 1; cyc <= 40000; cyc++) begin
            step(1);
            if (time_q.seconds !== s) return;
        end
        miscompares++;
        stop_test();
    endtask : wait_tick

    initial begin
        step(5);
        chk("reg_en in reset", 32'h0, reg_en);
        rstn_i = 1'b1;
        step(2);
        chk("reg_en", 32'h1, reg_en);
        chk("time", 32'h0, time_q);
        chk("alarm", 32'h0, alarm_q);
        chk("cal", 32'h0, {cal_wq, cal_mq});
        chk("reset flag", 32'h1, flags[rtc_pkg::IRQ_TMR_RST]);
        chk("mask", 32'h7, mask_q);
        chk("irq stopped", 32'h0, {irq, stopped});
        mask = 3'h3;
        pulse(mask_we);
        step(1);
        chk("irq unmask", 32'h1, irq);
        clr = 3'h4;
        step(1);
        clr = 3'h0;
        step(1);
        chk("irq clear", 32'h0, {irq, flags[2]});
        for (int s = 0; s < 32; s++) begin
            for (int p = 0; p < 3; p++) begin
                straps = s[4:0];
                pwr = p[1:0];
                step(2);
                exp_1v3 = straps >= rtc_pkg::STRAP_HI_FIRST && straps <= rtc_pkg::STRAP_HI_LAST && p == 1;
                chk("volt sel", {31'h0, exp_1v3}, reg_1v3);
            end
        end
        cal_w = 5'h0f;
        cal_m = 2'h3;
        pwr = 2'h0;
        alarm = {17'h00000, 15'h0006};
        pulse(alarm_we);
        tim = {rtc_pkg::SEC_DAY_LAST, 15'h0005};
        pulse(time_we);
        chk("cal load", 32'h3f, {cal_wq, cal_mq});
        chk("alarm load", {17'h00000, 15'h0006}, alarm_q);
        mask = 3'h0;
        pulse(mask_we);
        clr = 3'h7;
        step(1);
        clr = 3'h0;
        run = 1'b1;
        wait_tick(n);
        chk("rollover", {17'h00000, 15'h0006}, time_q);
        step(1);
        chk("alarm flag", 32'h1, flags[1]);
        step(1);
        chk("wake off", 32'h1, wake);
        pwr = 2'h1;
        step(2);
        chk("wake on", 32'h0, wake);
        wait_tick(n);
        chk("period cal", rtc_pkg::TB_DIV_NOM - 15, n + 4);
        clr = 3'h1;
        step(1);
        clr = 3'h0;
        step(1);
        chk("flags", 32'h5, {flags[1:0], irq});
        cal_w = 5'h10;
        cal_m = 2'h1;
        pwr = 2'h2;
        dis = 1'b1;
        step(1000);
        chk("stopped", 32'h1, stopped);
        dis = 1'b0;
        wait_tick(n);
        chk("period coin", rtc_pkg::TB_DIV_NOM + 1000, n + 1002);
        chk("tick flag", 32'h1, flags[0]);
        stop_test();
    end
endmodule : tb_rtc_core
